/* rtl/kwu_pkg.sv */
// key-on wakeup package: register map, field layout, reset values, types
// assumes a byte-wide register port with one-cycle read latency
package kwu_pkg;
	// ---------------------------------------------------------------
	// register map
	// ---------------------------------------------------------------
	localparam logic [11:0] KWU_ADDR_ENABLE = 12'hFAA;
	localparam logic [11:0] KWU_ADDR_STATUS = 12'hFB0;
	localparam logic [11:0] KWU_ADDR_IRQ_STAT = 12'hFB1;
	localparam logic [11:0] KWU_ADDR_IRQ_MASK = 12'hFB2;
	localparam logic [11:0] KWU_ADDR_CTRL = 12'hFB3;
	// ---------------------------------------------------------------
	// field layout and reset values
	// ---------------------------------------------------------------
	localparam int KWU_EN_LSB = 4;
	localparam int KWU_NPINS = 4;
	localparam logic [3:0] KWU_EN_RESET = 4'h0;
	localparam logic [7:0] KWU_UNMAPPED_READ = 8'h00;
	// irq status bits: 0 wake request, 1 standby refused, 2 standby released
	localparam int KWU_IRQ_WAKE = 0;
	localparam int KWU_IRQ_REFUSED = 1;
	localparam int KWU_IRQ_RELEASED = 2;
	localparam logic [2:0] KWU_IRQ_RESET = 3'h0;
	// ctrl bits: 0 release_mode_sel, 1 standby entry command (self clearing)
	localparam int KWU_CTRL_MODE = 0;
	localparam int KWU_CTRL_ENTER = 1;
	localparam logic KWU_MODE_RESET = 1'b1;

	typedef struct packed {
		logic [11:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} kwu_bus_req_t;

	typedef enum logic [1:0] {
		KWU_RUN,
		KWU_STANDBY,
		KWU_WARMUP
	} kwu_state_t;
endpackage : kwu_pkg

/* rtl/kwu_key_wakeup.sv */
// key-on wakeup: wake enable register, wake request, standby entry/release
// assumes wake pins and exit pin already synchronous to sys_clk
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ns
`default_nettype none

// What this block does
// - enable bits 7..4, one per wake pin
// - enables write-only, reset to zero
// - enabled wake pin low releases standby in level release mode
// - exit pin level or rising edge release
// - pending wake at entry skips to warm-up
// - wake detector has own input path
module kwu_key_wakeup
	import kwu_pkg::*;
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic srst,
	// register port
	input wire kwu_bus_req_t bus_req,
	output logic [7:0] rdata,
	// wake inputs (dedicated detector path, not port data)
	input wire logic [3:0] wake_pin,
	input wire logic stop_exit_pin,
	// standby sequencer hand-off
	output logic wake_request,
	output logic standby,
	output logic warmup_start,
	output logic irq
);
	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	logic [3:0] wake_en, next_wake_en;
	logic mode_level, next_mode_level;
	logic [2:0] irq_stat, next_irq_stat;
	logic [2:0] irq_mask, next_irq_mask;
	kwu_state_t state, next_state;
	logic exit_prev, next_exit_prev;
	logic [7:0] next_rdata;
	logic next_wake_request, next_standby, next_warmup_start, next_irq;
	logic exit_rise, key_hit, wake_now, enter_cmd;
	logic [2:0] irq_event;
	logic [3:0] pin_hit;
	logic [7:0] status_word;

	// ---------------------------------------------------------------
	// per-pin key match
	// ---------------------------------------------------------------
	// wake pins only count in level release mode
	for (genvar gi = 0; gi < KWU_NPINS; gi++) begin : g_pin
		kwu_pin_match match_u (
			.enable(wake_en[gi]),
			.pin_level(wake_pin[gi]),
			.level_mode(mode_level),
			.hit(pin_hit[gi])
		);
	end

	// ---------------------------------------------------------------
	// wake request
	// ---------------------------------------------------------------
	always_comb begin
		exit_rise = stop_exit_pin & ~exit_prev;
		// detector pins, never the port data input
		key_hit = |pin_hit;
		wake_now = key_hit | (mode_level ? stop_exit_pin : exit_rise);
		enter_cmd = bus_req.wr && bus_req.addr == KWU_ADDR_CTRL && bus_req.wdata[KWU_CTRL_ENTER];
	end

	// ---------------------------------------------------------------
	// standby sequencing
	// ---------------------------------------------------------------
	always_comb begin
		next_state = state;
		next_warmup_start = 1'b0;
		irq_event = 3'h0;
		next_exit_prev = stop_exit_pin;
		case (state)
			KWU_RUN: begin
				if (enter_cmd) begin
					// pending source at entry: go straight to warm-up
					if (key_hit || stop_exit_pin) begin
						next_state = KWU_WARMUP;
						irq_event[KWU_IRQ_REFUSED] = 1'b1;
					end else begin
						next_state = KWU_STANDBY;
					end
				end
			end
			KWU_STANDBY: begin
				if (wake_now) begin
					next_state = KWU_WARMUP;
					irq_event[KWU_IRQ_WAKE] = 1'b1;
				end
			end
			KWU_WARMUP: begin
				next_warmup_start = 1'b1;
				next_state = KWU_RUN;
				irq_event[KWU_IRQ_RELEASED] = 1'b1;
			end
			default: next_state = KWU_RUN;
		endcase
		next_wake_request = (state == KWU_STANDBY) && wake_now;
		next_standby = (next_state == KWU_STANDBY);
	end

	// ---------------------------------------------------------------
	// registers
	// ---------------------------------------------------------------
	always_comb begin
		next_wake_en = wake_en;
		next_mode_level = mode_level;
		next_irq_mask = irq_mask;
		next_irq_stat = irq_stat;
		next_rdata = KWU_UNMAPPED_READ;
		if (bus_req.wr) begin
			case (bus_req.addr)
				KWU_ADDR_ENABLE: next_wake_en = bus_req.wdata[KWU_EN_LSB +: KWU_NPINS];
				KWU_ADDR_IRQ_STAT: next_irq_stat = irq_stat & ~bus_req.wdata[2:0];
				KWU_ADDR_IRQ_MASK: next_irq_mask = bus_req.wdata[2:0];
				KWU_ADDR_CTRL: next_mode_level = bus_req.wdata[KWU_CTRL_MODE];
				default: next_wake_en = wake_en;
			endcase
		end
		// set wins over a clear in the same cycle
		next_irq_stat = next_irq_stat | irq_event;
		if (bus_req.rd) begin
			case (bus_req.addr)
				// enable register is write-only and reads as zero
				KWU_ADDR_ENABLE: next_rdata = KWU_UNMAPPED_READ;
				KWU_ADDR_STATUS: next_rdata = status_word;
				KWU_ADDR_IRQ_STAT: next_rdata = {5'h00, irq_stat};
				KWU_ADDR_IRQ_MASK: next_rdata = {5'h00, irq_mask};
				KWU_ADDR_CTRL: next_rdata = {7'h00, mode_level};
				default: next_rdata = KWU_UNMAPPED_READ;
			endcase
		end
		next_irq = |(next_irq_stat & next_irq_mask);
	end

	// ---------------------------------------------------------------
	// status word
	// ---------------------------------------------------------------
	// pin levels as the wake detector sees them
	always_comb begin
		status_word = 8'h00;
		status_word[7:4] = wake_pin;
		status_word[2] = stop_exit_pin;
		status_word[1] = (state == KWU_STANDBY);
		status_word[0] = (state == KWU_WARMUP);
	end

	// ---------------------------------------------------------------
	// sequencing flops
	// ---------------------------------------------------------------
	// exit_prev clears on reset, so a pin held high reads as a rising edge in the first cycle
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			state <= KWU_RUN;
			exit_prev <= 1'b0;
			wake_request <= 1'b0;
			standby <= 1'b0;
			warmup_start <= 1'b0;
		end else begin
			state <= next_state;
			exit_prev <= next_exit_prev;
			wake_request <= next_wake_request;
			standby <= next_standby;
			warmup_start <= next_warmup_start;
		end
	end

	// ---------------------------------------------------------------
	// register flops
	// ---------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			wake_en <= KWU_EN_RESET;
			mode_level <= KWU_MODE_RESET;
			irq_stat <= KWU_IRQ_RESET;
			irq_mask <= KWU_IRQ_RESET;
		end else begin
			wake_en <= next_wake_en;
			mode_level <= next_mode_level;
			irq_stat <= next_irq_stat;
			irq_mask <= next_irq_mask;
		end
	end

	// ---------------------------------------------------------------
	// bus and interrupt output flops
	// ---------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			rdata <= KWU_UNMAPPED_READ;
			irq <= 1'b0;
		end else begin
			rdata <= next_rdata;
			irq <= next_irq;
		end
	end
endmodule : kwu_key_wakeup

// ---------------------------------------------------------------
// one wake pin: enabled, low, level release mode
// ---------------------------------------------------------------
module kwu_pin_match (
	// match inputs
	input wire logic enable,
	input wire logic pin_level,
	input wire logic level_mode,
	// match result
	output logic hit
);
	always_comb begin
		hit = enable & ~pin_level & level_mode;
	end
endmodule : kwu_pin_match

`default_nettype wire

/* testbench/kwu_monitor.sv */
// checker: port relations of the key wakeup block
// assumes kwu_pkg is compiled first; bound below
`timescale 1ns/1ns
`default_nettype none
module kwu_monitor import kwu_pkg::*; (
	// clock and reset
	input wire logic sys_clk,
	input wire logic srst,
	// watched ports
	input wire kwu_bus_req_t bus_req,
	input wire logic [7:0] rdata,
	input wire logic [3:0] wake_pin,
	input wire logic stop_exit_pin,
	input wire logic wake_request,
	input wire logic standby,
	input wire logic warmup_start,
	input wire logic irq
);
	// ----
	// checks
	// ----
	default clocking mon_cb @(posedge sys_clk); endclocking
	default disable iff (srst);
	enable_wo_a: assert property (bus_req.rd && bus_req.addr == KWU_ADDR_ENABLE |=> rdata == 8'h00)
		else $error("enable reads back");
	rdata_idle_a: assert property (!$past(bus_req.rd) |-> rdata == 8'h00)
		else $error("rdata not idle");
	exit_release_a: assert property (standby && $rose(stop_exit_pin) |=> !standby && wake_request ##1 warmup_start)
		else $error("exit pin ignored");
	wake_cause_a: assert property (wake_request |-> $past(standby) && !standby)
		else $error("stray wake");
	entry_refused_a: assert property (
		bus_req.wr && bus_req.addr == KWU_ADDR_CTRL && bus_req.wdata[1] && stop_exit_pin
		&& !standby |=> !standby ##1 warmup_start) else $error("entry not refused");
	entry_taken_a: assert property (
		bus_req.wr && bus_req.addr == KWU_ADDR_CTRL && bus_req.wdata[1] && !stop_exit_pin
		&& &wake_pin && !standby |=> standby) else $error("entry lost");
	standby_held_a: assert property (standby && &wake_pin && !stop_exit_pin |=> standby)
		else $error("left standby");
	warmup_pulse_a: assert property (warmup_start |=> !warmup_start)
		else $error("long warmup pulse");
	no_overlap_a: assert property (warmup_start |-> !standby)
		else $error("warmup in standby");
endmodule : kwu_monitor
bind kwu_key_wakeup kwu_monitor mon_u (.sys_clk(sys_clk), .srst(srst), .bus_req(bus_req), .rdata(rdata),
	.wake_pin(wake_pin), .stop_exit_pin(stop_exit_pin), .wake_request(wake_request), .standby(standby),
	.warmup_start(warmup_start), .irq(irq));
`default_nettype wire

/* testbench/kwu_keys.sv */
// key pad model: pulled-up keys on the wake pins, active-high exit pin
// assumes the bench drives presses at clock edges
`timescale 1ns/1ns
`default_nettype none
module kwu_keys (
	// presses from the bench
	input wire logic [3:0] press,
	input wire logic exit_press,
	// pins to the device
	output logic [3:0] wake_pin,
	output logic stop_exit_pin
);
	// ----
	// pad levels
	// ----
	// released key reads high through its pull-up
	assign wake_pin = ~press;
	assign stop_exit_pin = exit_press;
endmodule : kwu_keys
`default_nettype wire

/* testbench/tb_top.sv */
// bench: wake table, then edge mode, refusal and interrupt cases
// assumes kwu_pkg, kwu_keys and kwu_monitor compiled first
`timescale 1ns/1ns
`default_nettype none
module tb_top import kwu_pkg::*;;
	logic sys_clk = 0, srst = 1, exit_press = 0, wake_request, standby, warmup_start, irq, stop_exit_pin;
	logic [3:0] press = 4'h0, wake_pin;
	logic [7:0] rdata, v;
	kwu_bus_req_t bus_req = '0;
	int err_count = 0, comparisons = 0, cyc = 0;
	// enable nibble, keys pressed, standby expected after press
	logic [11:0] rows [5] = '{12'hF10, 12'h110, 12'h121, 12'h880, 12'h0F1};
	kwu_key_wakeup dut_u (.sys_clk(sys_clk), .srst(srst), .bus_req(bus_req), .rdata(rdata), .wake_pin(wake_pin),
		.stop_exit_pin(stop_exit_pin), .wake_request(wake_request), .standby(standby), .warmup_start(warmup_start),
		.irq(irq));
	kwu_keys keys_u (.press(press), .exit_press(exit_press), .wake_pin(wake_pin), .stop_exit_pin(stop_exit_pin));
	// ----
	// clock, timeout, tasks
	// ----
	initial forever #10 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			err_count++;
			conclude();
		end
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge sys_clk);
		bus_req.wr <= 1'b0;
		#1;
	endtask : wr
	task automatic rd(input logic [11:0] a);
		@(posedge sys_clk);
		bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge sys_clk);
		bus_req.rd <= 1'b0;
		#1 v = rdata;
	endtask : rd
	// wait out warm-up by polling the status register
	task automatic settle();
		v = 8'h01;
		for (int i = 0; i < 20 && v[0] !== 1'b0; i++) rd(KWU_ADDR_STATUS);
		chk({7'h0, v[0]}, 8'h00);
	endtask : settle
	task automatic conclude();
		$display("comparisons=%0d err_count=%0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : conclude
	// ----
	// sequence
	// ----
	initial begin
		repeat (4) @(posedge sys_clk);
		srst <= 1'b0;
		#1 chk({4'h0, standby, warmup_start, wake_request, irq}, 8'h00);
		rd(KWU_ADDR_ENABLE);
		chk(v, 8'h00);
		rd(12'h000);
		chk(v, KWU_UNMAPPED_READ);
		wr(KWU_ADDR_IRQ_MASK, 8'h01);
		foreach (rows[i]) begin
			wr(KWU_ADDR_ENABLE, {rows[i][11:8], 4'hA});
			wr(KWU_ADDR_CTRL, 8'h03);
			chk({7'h0, standby}, 8'h01);
			@(posedge sys_clk);
			press <= rows[i][7:4];
			@(posedge sys_clk);
			#1 chk({7'h0, wake_request}, {7'h0, ~rows[i][0]});
			@(posedge sys_clk);
			#1 chk({7'h0, standby}, {7'h0, rows[i][0]});
			@(posedge sys_clk);
			press <= 4'h0;
			exit_press <= rows[i][0];
			@(posedge sys_clk);
			exit_press <= 1'b0;
			settle();
			chk({7'h0, irq}, 8'h01);
			wr(KWU_ADDR_IRQ_STAT, 8'h07);
			@(posedge sys_clk);
			#1 chk({7'h0, irq}, 8'h00);
		end
		wr(KWU_ADDR_ENABLE, 8'h00);
		wr(KWU_ADDR_CTRL, 8'h02);
		@(posedge sys_clk);
		press <= 4'hF;
		repeat (3) @(posedge sys_clk);
		#1 chk({7'h0, standby}, 8'h01);
		@(posedge sys_clk);
		exit_press <= 1'b1;
		repeat (2) @(posedge sys_clk);
		#1 chk({7'h0, standby}, 8'h00);
		settle();
		wr(KWU_ADDR_IRQ_STAT, 8'h07);
		wr(KWU_ADDR_CTRL, 8'h03);
		chk({7'h0, standby}, 8'h00);
		@(posedge sys_clk);
		#1 chk({7'h0, warmup_start}, 8'h01);
		settle();
		chk({7'h0, irq}, 8'h00);
		conclude();
	end
endmodule : tb_top
`default_nettype wire
